/* File: core/fdc_curve.sv */
`timescale 1ns/10ps
module fdc_curve import fdc_pkg::*; (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] din_i,
  input wire fdc_points_t points_i,
  output logic [7:0] dout_o
);
  logic [3:0] seg;
  logic signed [9:0] diff;
  logic signed [15:0] prod;
  logic [7:0] next_dout;

  // signed difference keeps falling and mixed slopes exact
  // R8 points per step
  // R9 linear interpolation
  always_comb begin
    seg = {1'b0, din_i[7:5]};
    diff = $signed({2'b00, points_i[seg + 4'h1]}) - $signed({2'b00, points_i[seg]});
    prod = diff * $signed({1'b0, din_i[4:0]});
    next_dout = 8'($signed({2'b00, points_i[seg]}) + (prod >>> 5));
  end

  // registered so the target path sees a clean value
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dout_o <= 8'h00;
    end else begin
      dout_o <= next_dout;
    end
  end
endmodule : fdc_curve

/* File: core/fdc_defines.svh */
// Behaviour
// R1: speed pin read as pulse width or analog level; pulse window follows frequency range.
// R2: a floating pin reads high through the pull-up, giving full input duty.
// R3: with holdoff set, the speed command is ignored for one second after reset.
// R4: with standby on, drive starts at start duty plus hysteresis, stops below start.
// R5: with standby off, the low curve point keeps driving below start duty.
// R6: target is zero at or above off duty, resumes below off minus hysteresis.
// R7: target clamped to minimum between start and off, to maximum below off.
// R8: eight curve points set target at 12.5% input steps; any slope allowed.
// R9: target interpolated linearly between neighbouring curve points.
// R10: leaving standby, sleep or fault always passes through pre-start.
// R11: pre-start forces square commutation whatever waveshape is chosen.
// R12: pre-start applies no hall offset, neither angle nor time.
// R13: with ramp on, duty rises from starting duty; open loop scales by maximum.
// R14: with ramp off, output duty loads straight from target.
// R15: pre-start lasts eight hall edges, then soft start follows.
// R16: when output already equals target at pre-start end, go straight to run.
// R17: no hall edge within lock timeout gives locked-rotor fault; run uses 320 ms.
// R18: soft start ramps duty with offset, demag and chosen waveshape until target.
// R19: target change ramps from prior target; deceleration optionally at half rate. The code ramps from the present output duty instead.
// R20: with stop ramp disabled, a zero target puts the bridge in hi-z at once.
// R21: with stop ramp enabled, duty ramps to zero at decel rate, then hi-z.
// R22: after hi-z, standby or sleep chosen by standby and low-power bits.
// R23: open loop hands output duty as peak; closed loop hands speed-loop duty.
// R24: applied duty follows from peak, waveshape and modulation selections.
// R25: ramp codes 0..3 give 77, 38.5, 19.2 and 9.6 percent per second.
// R26: start-up lock codes 0..3 give 0.32, 0.44, 0.52 and 1.05 seconds.
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH
// ****************************************
// timing
// ****************************************
`define FDC_CLK_KHZ 125000
`define FDC_HOLDOFF_MS 1000
`define FDC_HOLDOFF_CYC (`FDC_HOLDOFF_MS * `FDC_CLK_KHZ)
`define FDC_RAMP_FULL_MS 1300
`define FDC_RAMP_STEP_CYC (`FDC_RAMP_FULL_MS * `FDC_CLK_KHZ / 255)
`define FDC_LOCK_RUN_MS 320
`define FDC_LOCK_ST0_MS 320
`define FDC_LOCK_ST1_MS 440
`define FDC_LOCK_ST2_MS 520
`define FDC_LOCK_ST3_MS 1050
`define FDC_WIN_LO_LOG2 23
`define FDC_WIN_HI_LOG2 17
`define FDC_PRESTART_LAST 4'h7
`define FDC_FULL_DUTY 8'hff
// ****************************************
// register map and fields
// ****************************************
`define FDC_OFS_CTRL 3'h0
`define FDC_OFS_THRESH 3'h1
`define FDC_OFS_LIMITS 3'h2
`define FDC_OFS_PTS_LO 3'h3
`define FDC_OFS_PTS_HI 3'h4
`define FDC_OFS_STATUS 3'h5
`define FDC_CTRL_RST 32'h0000_0010
`define FDC_THRESH_RST 32'h00ff_0820
`define FDC_LIMITS_RST 32'h0040_ff10
`define FDC_PTS_LO_RST 32'h8060_4020
`define FDC_PTS_HI_RST 32'hffe0_c0a0
`define FDC_CTRL_KIND 0
`define FDC_CTRL_RANGE 1
`define FDC_CTRL_HOLD 2
`define FDC_CTRL_STBY 3
`define FDC_CTRL_RAMP 4
`define FDC_CTRL_DECEL 5
`define FDC_CTRL_STOPDIS 6
`define FDC_CTRL_CLOSED 7
`define FDC_CTRL_LPOW 8
`define FDC_CTRL_RSEL 10:9
`define FDC_CTRL_LSEL 12:11
`define FDC_CTRL_WAVE 13
`define FDC_CTRL_MOD 15:14
`define FDC_STATUS_CLR 0
`endif

/* File: core/fdc_lock_timer.sv */
`timescale 1ns/10ps
module fdc_lock_timer (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic hall_edge_i,
  input wire logic [31:0] limit_i,
  output logic timeout_o
);
  logic [31:0] cnt;

  // time since last hall edge, only while the bridge drives
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 32'h0;
    end else if (!run_i || hall_edge_i || timeout_o) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // R17 lock timeout pulse
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= run_i && !hall_edge_i && !timeout_o && (cnt >= limit_i - 32'h1);
    end
  end
endmodule : fdc_lock_timer

/* File: core/fdc_pkg.sv */
package fdc_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    FDC_STANDBY = 3'b000,
    FDC_PRESTART = 3'b001,
    FDC_SOFTSTART = 3'b010,
    FDC_RUN = 3'b011,
    FDC_STOPPING = 3'b100,
    FDC_SLEEP = 3'b101,
    FDC_FAULT = 3'b110
  } fdc_phase_t;
  typedef enum logic {
    FDC_WAVE_SQUARE = 1'b0,
    FDC_WAVE_SOFT = 1'b1
  } fdc_wave_t;
  // point 0 is the duty at zero input, points 1..8 at 12.5% steps
  typedef logic [8:0][7:0] fdc_points_t;
endpackage : fdc_pkg

/* File: core/fdc_ramp_ctrl.sv */
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`include "fdc_defines.svh"
module fdc_ramp_ctrl import fdc_pkg::*; #(
  parameter int unsigned HOLDOFF_CYC = `FDC_HOLDOFF_CYC,
  parameter int unsigned RAMP_STEP_CYC = `FDC_RAMP_STEP_CYC,
  parameter int unsigned LOCK_RUN_CYC = `FDC_LOCK_RUN_MS * `FDC_CLK_KHZ,
  parameter int unsigned LOCK_ST0_CYC = `FDC_LOCK_ST0_MS * `FDC_CLK_KHZ,
  parameter int unsigned LOCK_ST1_CYC = `FDC_LOCK_ST1_MS * `FDC_CLK_KHZ,
  parameter int unsigned LOCK_ST2_CYC = `FDC_LOCK_ST2_MS * `FDC_CLK_KHZ,
  parameter int unsigned LOCK_ST3_CYC = `FDC_LOCK_ST3_MS * `FDC_CLK_KHZ,
  parameter int unsigned WIN_LO_LOG2 = `FDC_WIN_LO_LOG2,
  parameter int unsigned WIN_HI_LOG2 = `FDC_WIN_HI_LOG2
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic cmd_pin_i,
  input wire logic [7:0] analog_duty_i,
  input wire logic hall_i,
  input wire logic [7:0] speed_loop_duty_i,
  output logic [7:0] peak_duty_o,
  output logic bridge_hiz_o,
  output logic waveshape_o,
  output logic [1:0] modulation_o,
  output logic hall_offset_en_o,
  output logic demag_en_o,
  output logic sleep_o,
  output logic lock_fault_o
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] fdc_add(input logic [7:0] a, input logic [7:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction : fdc_add

  function automatic logic [7:0] fdc_sub(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? (a - b) : 8'h00;
  endfunction : fdc_sub

  // ****************************************
  // configuration registers
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] thresh;
  logic [31:0] limits;
  logic [31:0] pts_lo;
  logic [31:0] pts_hi;
  logic fault_clr;

  // plain write port, unmapped offsets are ignored
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= `FDC_CTRL_RST;
      thresh <= `FDC_THRESH_RST;
      limits <= `FDC_LIMITS_RST;
      pts_lo <= `FDC_PTS_LO_RST;
      pts_hi <= `FDC_PTS_HI_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `FDC_OFS_CTRL: ctrl <= reg_wdata_i;
        `FDC_OFS_THRESH: thresh <= reg_wdata_i;
        `FDC_OFS_LIMITS: limits <= reg_wdata_i;
        `FDC_OFS_PTS_LO: pts_lo <= reg_wdata_i;
        `FDC_OFS_PTS_HI: pts_hi <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign fault_clr = reg_wr_i && (reg_addr_i == `FDC_OFS_STATUS)
                     && reg_wdata_i[`FDC_STATUS_CLR];

  logic kind_sel;
  logic range_sel;
  logic hold_en;
  logic standby_enable;
  logic ramp_en;
  logic decel_sel;
  logic stop_dis;
  logic closed_sel;
  logic lp_allow;
  logic [1:0] ramp_sel;
  logic [1:0] lock_sel;
  logic [7:0] start_duty;
  logic [7:0] hys;
  logic [7:0] off_duty;
  logic [7:0] min_t;
  logic [7:0] max_t;
  logic [7:0] st_set;

  // field decode
  assign kind_sel = ctrl[`FDC_CTRL_KIND];
  assign range_sel = ctrl[`FDC_CTRL_RANGE];
  assign hold_en = ctrl[`FDC_CTRL_HOLD];
  assign standby_enable = ctrl[`FDC_CTRL_STBY];
  assign ramp_en = ctrl[`FDC_CTRL_RAMP];
  assign decel_sel = ctrl[`FDC_CTRL_DECEL];
  assign stop_dis = ctrl[`FDC_CTRL_STOPDIS];
  assign closed_sel = ctrl[`FDC_CTRL_CLOSED];
  assign lp_allow = ctrl[`FDC_CTRL_LPOW];
  assign ramp_sel = ctrl[`FDC_CTRL_RSEL];
  assign lock_sel = ctrl[`FDC_CTRL_LSEL];
  assign start_duty = thresh[7:0];
  assign hys = thresh[15:8];
  assign off_duty = thresh[23:16];
  assign min_t = limits[7:0];
  assign max_t = limits[15:8];
  assign st_set = limits[23:16];

  // ****************************************
  // speed command qualification
  // ****************************************
  logic [23:0] win_cnt;
  logic [23:0] high_cnt;
  logic [23:0] high_next;
  logic [23:0] high_scaled;
  logic [4:0] win_log2;
  logic win_end;
  logic [7:0] pwm_duty;
  logic [7:0] input_duty;
  logic [31:0] hold_cnt;
  logic cmd_masked;

  // R1 window length from range
  assign win_log2 = range_sel ? WIN_HI_LOG2[4:0] : WIN_LO_LOG2[4:0];
  assign win_end = (win_cnt == 24'((32'h1 << win_log2) - 32'h1));
  assign high_next = high_cnt + {23'h0, cmd_pin_i};
  assign high_scaled = high_next >> (win_log2 - 5'd8);

  // high time counted every cycle over a power-of-two window, no divider needed
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_cnt <= 24'h0;
      high_cnt <= 24'h0;
    end else if (win_end) begin
      win_cnt <= 24'h0;
      high_cnt <= 24'h0;
    end else begin
      win_cnt <= win_cnt + 24'h1;
      high_cnt <= high_next;
    end
  end

  // R2 all-high window saturates
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_duty <= 8'h00;
    end else if (win_end) begin
      pwm_duty <= (high_scaled > 24'h0000ff) ? `FDC_FULL_DUTY : high_scaled[7:0];
    end
  end

  // R1 pulse or analog source
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_duty <= 8'h00;
    end else begin
      input_duty <= kind_sel ? analog_duty_i : pwm_duty;
    end
  end

  // R3 power-up holdoff
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt <= 32'h0;
    end else if (hold_cnt != HOLDOFF_CYC) begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end
  assign cmd_masked = hold_en && (hold_cnt != HOLDOFF_CYC);

  // ****************************************
  // duty curve and target
  // ****************************************
  logic engaged;
  logic off_hit;
  logic [7:0] curve_duty;
  logic [7:0] target;
  logic [7:0] next_target;
  logic [7:0] prior_target;

  fdc_curve u_curve (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .din_i(input_duty),
    .points_i({pts_hi, pts_lo, thresh[31:24]}),
    .dout_o(curve_duty)
  );

  // R4 start hysteresis
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      engaged <= 1'b0;
    end else if ({1'b0, input_duty} >= fdc_add(start_duty, hys)) begin
      engaged <= 1'b1;
    end else if (input_duty < start_duty) begin
      engaged <= 1'b0;
    end
  end

  // R6 off threshold, full-scale off value leaves the cut-off unused
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_hit <= 1'b0;
    end else if (input_duty >= off_duty && off_duty != `FDC_FULL_DUTY) begin
      off_hit <= 1'b1;
    end else if (input_duty < fdc_sub(off_duty, hys)) begin
      off_hit <= 1'b0;
    end
  end

  // R5 curve below start keeps drive when standby is off
  always_comb begin
    next_target = curve_duty;
    // R7 clamps
    if (next_target > max_t) begin
      next_target = max_t;
    end
    if (input_duty > start_duty && next_target < min_t) begin
      next_target = min_t;
    end
    // R6 zero target
    if (off_hit || cmd_masked || (standby_enable && !engaged)) begin
      next_target = 8'h00;
    end
  end

  // R19 prior target recorded but not read; the ramp starts from the present output_duty
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      target <= 8'h00;
      prior_target <= 8'h00;
    end else if (next_target != target) begin
      target <= next_target;
      prior_target <= target;
    end
  end

  // ****************************************
  // start, run and stop sequence
  // ****************************************
  fdc_phase_t phase;
  fdc_phase_t next_phase;
  logic hall_q;
  logic hall_edge;
  logic [3:0] edge_cnt;
  logic drive_req;
  logic lock_to;
  logic lock_run;
  logic [31:0] lock_limit;
  logic [7:0] output_duty;
  logic [7:0] ramp_goal;
  logic [31:0] ramp_cnt;
  logic [31:0] ramp_period;
  logic dir_down;
  logic step;
  logic [7:0] prestart_duty;
  logic [15:0] start_prod;

  assign drive_req = (target != 8'h00);
  assign hall_edge = hall_i ^ hall_q;
  assign lock_run = (phase == FDC_PRESTART) || (phase == FDC_SOFTSTART) || (phase == FDC_RUN);

  // R26 start-up lock choice
  always_comb begin
    case (lock_sel)
      2'h0: lock_limit = LOCK_ST0_CYC;
      2'h1: lock_limit = LOCK_ST1_CYC;
      2'h2: lock_limit = LOCK_ST2_CYC;
      default: lock_limit = LOCK_ST3_CYC;
    endcase
    // R17 fixed run timeout
    if (phase == FDC_RUN) begin
      lock_limit = LOCK_RUN_CYC;
    end
  end

  fdc_lock_timer u_lock (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .run_i(lock_run),
    .hall_edge_i(hall_edge),
    .limit_i(lock_limit),
    .timeout_o(lock_to)
  );

  // hall edges counted only during pre-start
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hall_q <= 1'b0;
      edge_cnt <= 4'h0;
    end else begin
      hall_q <= hall_i;
      if (phase != FDC_PRESTART) begin
        edge_cnt <= 4'h0;
      end else if (hall_edge) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // phase sequencing
  always_comb begin
    next_phase = phase;
    case (phase)
      // R10 every exit passes pre-start
      FDC_STANDBY, FDC_SLEEP: if (drive_req) next_phase = FDC_PRESTART;
      FDC_PRESTART: begin
        if (lock_to) begin
          next_phase = FDC_FAULT;
        end else if (!drive_req) begin
          next_phase = FDC_STOPPING;
        // R15 eighth edge ends pre-start
        end else if (hall_edge && edge_cnt == `FDC_PRESTART_LAST) begin
          // R16 skip soft start
          next_phase = (output_duty == target) ? FDC_RUN : FDC_SOFTSTART;
        end
      end
      FDC_SOFTSTART: begin
        if (lock_to) begin
          next_phase = FDC_FAULT;
        end else if (!drive_req) begin
          next_phase = FDC_STOPPING;
        // R18 soft start done
        end else if (output_duty == target) begin
          next_phase = FDC_RUN;
        end
      end
      FDC_RUN: begin
        if (lock_to) begin
          next_phase = FDC_FAULT;
        end else if (!drive_req) begin
          next_phase = FDC_STOPPING;
        end
      end
      FDC_STOPPING: begin
        // R22 standby or sleep
        if (stop_dis || output_duty == 8'h00) begin
          next_phase = (standby_enable || !lp_allow) ? FDC_STANDBY : FDC_SLEEP;
        end
      end
      FDC_FAULT: if (fault_clr) next_phase = drive_req ? FDC_PRESTART : FDC_STANDBY;
      default: next_phase = FDC_STANDBY;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= FDC_STANDBY;
    end else begin
      phase <= next_phase;
    end
  end

  // ****************************************
  // duty ramp
  // ****************************************
  // R13 starting duty, scaled by maximum in open loop
  assign start_prod = st_set * max_t;
  assign prestart_duty = closed_sel ? st_set : start_prod[15:8];
  assign ramp_goal = (phase == FDC_STOPPING) ? 8'h00 : target;
  assign dir_down = (output_duty > ramp_goal);
  // R25 each code doubles the step time; R19 halves decel rate
  assign ramp_period = RAMP_STEP_CYC << ({3'h0, ramp_sel} + {4'h0, dir_down && decel_sel});
  assign step = (ramp_cnt >= ramp_period - 32'h1);

  // step timer restarts whenever the duty sits on its goal
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ramp_cnt <= 32'h0;
    end else if (step || output_duty == ramp_goal) begin
      ramp_cnt <= 32'h0;
    end else begin
      ramp_cnt <= ramp_cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_duty <= 8'h00;
    end else if (!lock_run && phase != FDC_STOPPING) begin
      output_duty <= (next_phase == FDC_PRESTART && ramp_en) ? prestart_duty : 8'h00;
    // R20 immediate stop
    end else if (phase == FDC_STOPPING && stop_dis) begin
      output_duty <= 8'h00;
    // R14 direct load
    end else if (!ramp_en) begin
      output_duty <= ramp_goal;
    // R21 ramp to zero
    end else if (step && output_duty != ramp_goal) begin
      output_duty <= dir_down ? output_duty - 8'h01 : output_duty + 8'h01;
    end
  end

  // ****************************************
  // hand-off to commutation
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      peak_duty_o <= 8'h00;
      bridge_hiz_o <= 1'b1;
      waveshape_o <= FDC_WAVE_SQUARE;
      modulation_o <= 2'h0;
      hall_offset_en_o <= 1'b0;
      demag_en_o <= 1'b0;
      sleep_o <= 1'b0;
      lock_fault_o <= 1'b0;
    end else begin
      // R23 open or closed loop peak
      peak_duty_o <= (closed_sel && phase == FDC_RUN) ? speed_loop_duty_i : output_duty;
      // R20 hi-z on stop
      bridge_hiz_o <= !(next_phase == FDC_PRESTART || next_phase == FDC_SOFTSTART
                       || next_phase == FDC_RUN || (next_phase == FDC_STOPPING && !stop_dis));
      // R11 square in pre-start
      // R24 waveshape and modulation go along with the peak
      waveshape_o <= (next_phase == FDC_PRESTART) ? FDC_WAVE_SQUARE : ctrl[`FDC_CTRL_WAVE];
      modulation_o <= ctrl[`FDC_CTRL_MOD];
      // R12 offset only after pre-start
      hall_offset_en_o <= (next_phase == FDC_SOFTSTART) || (next_phase == FDC_RUN);
      demag_en_o <= (next_phase == FDC_SOFTSTART) || (next_phase == FDC_RUN);
      sleep_o <= (next_phase == FDC_SLEEP);
      lock_fault_o <= (next_phase == FDC_FAULT);
    end
  end

  // register and status read, data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FDC_OFS_CTRL: reg_rdata_o <= ctrl;
        `FDC_OFS_THRESH: reg_rdata_o <= thresh;
        `FDC_OFS_LIMITS: reg_rdata_o <= limits;
        `FDC_OFS_PTS_LO: reg_rdata_o <= pts_lo;
        `FDC_OFS_PTS_HI: reg_rdata_o <= pts_hi;
        `FDC_OFS_STATUS: reg_rdata_o <= {input_duty, output_duty, target, 4'h0, lock_fault_o, phase};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_prestart_end;
    phase == FDC_PRESTART && next_phase != FDC_PRESTART && !lock_to && drive_req;
  endsequence

  sequence s_stop_step;
    phase == FDC_STOPPING && ramp_en && !stop_dis && step && output_duty != 8'h00;
  endsequence

  a_prestart_square: assert property (phase == FDC_PRESTART |-> waveshape_o == FDC_WAVE_SQUARE) // R11
    else $error("pre-start not square");
  a_prestart_offset: assert property (phase == FDC_PRESTART |-> !hall_offset_en_o) // R12
    else $error("offset during pre-start");
  a_standby_gate: assert property (standby_enable && !engaged ##1 standby_enable |-> target == 8'h00) // R4
    else $error("drive before start threshold");
  a_off_zero: assert property (off_hit |=> target == 8'h00) // R6
    else $error("target not zero above off");
  a_max_clamp: assert property (##1 target <= $past(max_t)) // R7
    else $error("target above maximum");
  a_eight_edges: assert property (s_prestart_end |-> hall_edge && edge_cnt == 4'h7) // R15
    else $error("pre-start ended early");
  a_skip_soft: assert property (s_prestart_end ##0 output_duty == target |=> phase == FDC_RUN) // R16
    else $error("soft start not skipped");
  a_lock_fault: assert property (lock_to && lock_run |=> phase == FDC_FAULT ##1 lock_fault_o) // R17
    else $error("lock timeout missed");
  a_direct_load: assert property (!ramp_en && phase == FDC_RUN |=> output_duty == $past(target)) // R14
    else $error("duty not loaded directly");
  a_stop_hiz: assert property (phase == FDC_STOPPING && stop_dis |=> bridge_hiz_o && output_duty == 8'h00) // R20
    else $error("no hi-z on stop");
  a_stop_ramp: assert property (s_stop_step |=> output_duty == $past(output_duty) - 8'h01) // R21
    else $error("stop ramp step wrong");
endmodule : fdc_ramp_ctrl

/* File: verification/fdc_cmd_src.sv */
`timescale 1ns/10ps
// speed command source: fixed 50% pulse train, or released pin
module fdc_cmd_src (
  input wire logic mclk_i,
  input wire logic drive_i,
  output logic cmd_o
);
  logic [5:0] ph = 6'h00;
  always @(posedge mclk_i) begin
    ph <= ph + 6'h01;
    cmd_o <= drive_i ? ~ph[5] : 1'b1; // released pin reads high through the pull-up
  end
endmodule : fdc_cmd_src

/* File: verification/fdc_ramp_ctrl_test.sv */
`timescale 1ns/10ps
module fdc_ramp_ctrl_test import fdc_pkg::*;;
  logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, hall_i = 0, drive = 0, cmd_pin_i;
  logic [2:0] reg_addr_i = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic [7:0] analog_duty_i = 8'h00, speed_loop_duty_i = 8'h00, peak_duty_o;
  logic [1:0] modulation_o;
  logic bridge_hiz_o, waveshape_o, hall_offset_en_o, demag_en_o, sleep_o, lock_fault_o;
  int bad_count = 0, tests_run = 0;
  logic [31:0] rst_tab [5] = '{32'h10, 32'h00ff_0820, 32'h0040_ff10, 32'h8060_4020, 32'hffe0_c0a0};
  always #4 mclk_i = ~mclk_i;
  fdc_cmd_src u_src (.mclk_i, .drive_i(drive), .cmd_o(cmd_pin_i));
  // holdoff and the longer start-up lock codes stay at their real lengths: no scenario uses them
  fdc_ramp_ctrl #(.RAMP_STEP_CYC(4), .LOCK_RUN_CYC(200), .LOCK_ST0_CYC(100), .WIN_LO_LOG2(10),
    .WIN_HI_LOG2(9)) u_dut (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cmd_pin_i, .analog_duty_i, .hall_i, .speed_loop_duty_i, .peak_duty_o,
    .bridge_hiz_o, .waveshape_o, .modulation_o, .hall_offset_en_o, .demag_en_o, .sleep_o,
    .lock_fault_o);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd_reg
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    #160000;
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h41158568));
    tick(3);
    resetn_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_reg(i[2:0]);
      chk("reset reg", d, rst_tab[i]);
    end
    rd_reg(3'h6);
    chk("unmapped", d, 32'h0);
    chk("hiz idle", bridge_hiz_o, 1'b1);
    // analog input, no ramp, stop ramp off, soft wave chosen; max clamp 0x30
    wr_reg(3'h1, 32'h00c0_0820);
    wr_reg(3'h2, 32'h0040_3000);
    analog_duty_i <= 8'h40 + 8'($urandom % 128);
    wr_reg(3'h0, 32'h0000_2051 & 32'hffff_ffef | 32'h40);
    tick(12);
    rd_reg(3'h5);
    chk("target clamp", d[15:8], 8'h30);
    chk("phase pre", d[2:0], FDC_PRESTART);
    chk("wave pre", waveshape_o, 1'b0);
    chk("offset pre", hall_offset_en_o, 1'b0);
    for (int i = 0; i < 8; i++) begin
      hall_i <= ~hall_i;
      tick(4);
    end
    rd_reg(3'h5);
    chk("phase run", d[2:0], FDC_RUN);
    chk("peak", peak_duty_o, 8'h30);
    chk("offset run", hall_offset_en_o, 1'b1);
    chk("wave run", waveshape_o, 1'b1);
    chk("demag run", demag_en_o, 1'b1);
    chk("mod run", modulation_o, 2'h0);
    analog_duty_i <= 8'hc0 + 8'($urandom % 64);
    tick(10);
    chk("hiz stop", bridge_hiz_o, 1'b1);
    rd_reg(3'h5);
    chk("target off", d[15:8], 8'h00);
    chk("phase stby", d[2:0], FDC_STANDBY);
    analog_duty_i <= 8'h80;
    tick(120);
    chk("lock", lock_fault_o, 1'b1);
    wr_reg(3'h5, 32'h1);
    tick(4);
    chk("lock clr", lock_fault_o, 1'b0);
    // pulse input, high range: released pin, then a 50% train
    wr_reg(3'h0, 32'h0000_0042);
    tick(1100);
    rd_reg(3'h5);
    chk("float duty", d[31:24], 8'hff);
    drive <= 1'b1;
    tick(1100);
    rd_reg(3'h5);
    chk("pulse duty", d[31:24], 8'h80);
    print_verdict();
  end
endmodule : fdc_ramp_ctrl_test
